// ### rtl/rtci_pkg.sv
// Purpose: Shared constants and types of the clock-chip serial access port.
// Assumes: One 50 MHz system clock.
// Notes: All counts are derived from times stated in their own units.
package rtci_pkg;

	// ----------------------------------------
	// Link addressing
	// ----------------------------------------
	localparam logic [6:0] RTCI_SLAVE_ADDR = 7'h32;
	localparam logic [3:0] RTCI_PTR_RESET = 4'hf;
	localparam logic [3:0] RTCI_FMT_WRITE = 4'h0;
	localparam logic [3:0] RTCI_FMT_READ_NOW = 4'h4;
	localparam logic [7:0] RTCI_FILL_BYTE = 8'hff;
	localparam logic [3:0] RTCI_BITS_PER_BYTE = 4'h8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int RTCI_CLK_KHZ = 50000;
	localparam int RTCI_ACCESS_LIMIT_MS = 500;
	localparam int RTCI_ACCESS_LIMIT_CYC = RTCI_ACCESS_LIMIT_MS * RTCI_CLK_KHZ;
	localparam int RTCI_TMR_W = 25;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		RTCI_ST_IDLE,
		RTCI_ST_RX,
		RTCI_ST_RX_ACK,
		RTCI_ST_TX,
		RTCI_ST_TX_ACK,
		RTCI_ST_SKIP
	} rtci_state_t;

	typedef struct packed {
		logic valid;
		logic [3:0] addr;
		logic [7:0] data;
	} rtci_wr_t;

endpackage

// ### rtl/rtci_sync.sv
// Purpose: Two-stage synchroniser for the link pins.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/100ps
`default_nettype none
module rtci_sync #(
	parameter int W = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	import rtci_pkg::*;

	logic [W-1:0] meta_q;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					meta_q[g] <= 1'b1;
					sync_o[g] <= 1'b1;
				end
				else
				begin
					meta_q[g] <= async_i[g];
					sync_o[g] <= meta_q[g];
				end
			end
		end
	endgenerate

endmodule // rtci_sync
`default_nettype wire

// ### rtl/rtci_port.sv
// Purpose: Two-wire slave port giving a bus master access to the clock registers.
// Assumes: Register space sits outside; read data is returned in the same cycle.
// Notes: The link clock is oversampled by ref_clk; it must stay well below 12 MHz.
`timescale 1ns/100ps
`default_nettype none
module rtci_port #(
	parameter int ACCESS_LIMIT_CYC = rtci_pkg::RTCI_ACCESS_LIMIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output rtci_pkg::rtci_wr_t reg_wr,
	output logic [3:0] reg_rd_addr,
	input wire logic [7:0] reg_rd_data,
	output logic time_hold
);
	import rtci_pkg::*;

	// ----------------------------------------
	// Pin sampling and condition detection
	// ----------------------------------------
	logic [1:0] pins_s;
	logic scl_s, sda_s, scl_p_q, sda_p_q;
	logic scl_rise, scl_fall, start_det, stop_det;

	rtci_sync #(
		.W(2)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_i({scl_i, sda_i}),
		.sync_o(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

	// ----------------------------------------
	// Access time limit
	// ----------------------------------------
	// The limit runs from the first start; a repeated start does not restart it.
	logic [RTCI_TMR_W-1:0] tmr_q;
	logic tmr_act_q, tout_hit;

	assign tout_hit = tmr_act_q && (tmr_q == RTCI_TMR_W'(ACCESS_LIMIT_CYC - 1));

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tmr_q <= '0;
			tmr_act_q <= 1'b0;
		end
		else if (stop_det || tout_hit)
		begin
			tmr_q <= '0;
			tmr_act_q <= 1'b0;
		end
		else if (start_det && !tmr_act_q && !time_hold)
		begin
			tmr_q <= '0;
			tmr_act_q <= 1'b1;
		end
		else if (tmr_act_q)
		begin
			tmr_q <= tmr_q + 1'b1;
		end
	end

	// ----------------------------------------
	// Time hold and lockout after forced end
	// ----------------------------------------
	logic locked_q;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			time_hold <= 1'b0;
			locked_q <= 1'b0;
		end
		else if (stop_det)
		begin
			time_hold <= 1'b0;
			locked_q <= 1'b0;
		end
		else if (tout_hit)
		begin
			time_hold <= 1'b0;
			locked_q <= 1'b1;
		end
		else if (start_det && !locked_q)
		begin
			time_hold <= 1'b1;
		end
	end

	// ----------------------------------------
	// Byte engine
	// ----------------------------------------
	rtci_state_t st_q;
	logic [3:0] cnt_q;
	logic [1:0] idx_q;
	logic [7:0] rx_q, tx_q;
	logic [3:0] ptr_q;
	logic rw_q, ack_q, go_tx_q, mack_q;
	logic addr_ok;

	assign addr_ok = (rx_q[7:1] == RTCI_SLAVE_ADDR);
	assign reg_rd_addr = ptr_q;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= RTCI_ST_IDLE;
			cnt_q <= '0;
			idx_q <= '0;
			rx_q <= '0;
			tx_q <= RTCI_FILL_BYTE;
			ptr_q <= RTCI_PTR_RESET;
			rw_q <= 1'b0;
			ack_q <= 1'b0;
			go_tx_q <= 1'b0;
			mack_q <= 1'b0;
			reg_wr <= '0;
		end
		else
		begin
			reg_wr.valid <= 1'b0;
			if (stop_det)
			begin
				st_q <= RTCI_ST_IDLE;
				ptr_q <= RTCI_PTR_RESET;
			end
			else if (start_det)
			begin
				st_q <= RTCI_ST_RX;
				cnt_q <= '0;
				idx_q <= '0;
			end
			else if (tout_hit)
			begin
				st_q <= RTCI_ST_SKIP;
				ptr_q <= RTCI_PTR_RESET;
			end
			else
			begin
				case (st_q)
					RTCI_ST_RX:
					begin
						if (scl_rise)
						begin
							rx_q <= {rx_q[6:0], sda_s};
							cnt_q <= cnt_q + 1'b1;
						end
						else if (scl_fall && cnt_q == RTCI_BITS_PER_BYTE)
						begin
							st_q <= RTCI_ST_RX_ACK;
							go_tx_q <= 1'b0;
							ack_q <= 1'b1;
							if (idx_q == 2'd0)
							begin
								rw_q <= rx_q[0];
								ack_q <= addr_ok && !(locked_q && !rx_q[0]);
								go_tx_q <= rx_q[0];
								if (!addr_ok || (locked_q && !rx_q[0]))
								begin
									st_q <= RTCI_ST_SKIP;
								end
							end
							else if (idx_q == 2'd1)
							begin
								ptr_q <= rx_q[7:4];
								go_tx_q <= (rx_q[3:0] == RTCI_FMT_READ_NOW);
							end
							else
							begin
								reg_wr.valid <= 1'b1;
								reg_wr.addr <= ptr_q;
								reg_wr.data <= rx_q;
								ptr_q <= ptr_q + 1'b1;
							end
						end
					end
					RTCI_ST_RX_ACK:
					begin
						if (scl_fall)
						begin
							cnt_q <= '0;
							if (idx_q != 2'd2)
							begin
								idx_q <= idx_q + 1'b1;
							end
							if (go_tx_q)
							begin
								st_q <= RTCI_ST_TX;
								tx_q <= locked_q ? RTCI_FILL_BYTE : reg_rd_data;
								ptr_q <= ptr_q + 1'b1;
							end
							else
							begin
								st_q <= RTCI_ST_RX;
							end
						end
					end
					RTCI_ST_TX:
					begin
						if (scl_fall)
						begin
							tx_q <= {tx_q[6:0], 1'b1};
							cnt_q <= cnt_q + 1'b1;
							if (cnt_q == RTCI_BITS_PER_BYTE - 4'h1)
							begin
								st_q <= RTCI_ST_TX_ACK;
							end
						end
					end
					RTCI_ST_TX_ACK:
					begin
						if (scl_rise)
						begin
							mack_q <= !sda_s;
						end
						else if (scl_fall)
						begin
							cnt_q <= '0;
							if (mack_q)
							begin
								st_q <= RTCI_ST_TX;
								tx_q <= locked_q ? RTCI_FILL_BYTE : reg_rd_data;
								ptr_q <= ptr_q + 1'b1;
							end
							else
							begin
								st_q <= RTCI_ST_SKIP;
							end
						end
					end
					default:
					begin
						st_q <= st_q;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Open-drain data pin
	// ----------------------------------------
	// The pin level is never driven high; pull-ups supply the high level.
	assign sda_o = 1'b0;
	assign sda_oe = ((st_q == RTCI_ST_RX_ACK) && ack_q)
		|| ((st_q == RTCI_ST_TX) && !tx_q[7]);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sda_low_only_a: assert property (sda_o == 1'b0)
		else $error("data pin driven high");

	idle_release_a: assert property ((st_q == RTCI_ST_IDLE) || (st_q == RTCI_ST_SKIP)
		|-> !sda_oe)
		else $error("data pin held while idle");

	oe_stable_a: assert property (scl_s && $past(scl_s) && !$past(tout_hit)
		|-> $stable(sda_oe))
		else $error("data changed while clock high");

	start_seen_a: assert property (start_det && !stop_det
		|=> st_q == RTCI_ST_RX && cnt_q == 4'h0)
		else $error("start not taken");

	stop_ptr_a: assert property (stop_det
		|=> ptr_q == RTCI_PTR_RESET && !time_hold ##1 !sda_oe)
		else $error("stop did not end access");

	write_wrap_a: assert property (reg_wr.valid && reg_wr.addr == 4'hf |-> ptr_q == 4'h0)
		else $error("pointer did not wrap");

	foreign_nack_a: assert property (st_q == RTCI_ST_RX && scl_fall && cnt_q == 4'h8
		&& idx_q == 2'd0 && !addr_ok |=> !sda_oe [*3])
		else $error("foreign address acknowledged");

	// A missing master acknowledge must park the port so that the master can stop.
	tx_ack_release_a: assert property (st_q == RTCI_ST_TX_ACK && scl_fall
		&& !mack_q && !tout_hit |=> st_q == RTCI_ST_SKIP && !sda_oe)
		else $error("data held after master gave no acknowledge");

	timeout_end_a: assert property (tout_hit && !stop_det |=> ptr_q == RTCI_PTR_RESET
		&& locked_q && !time_hold)
		else $error("forced end incomplete");

	locked_ff_a: assert property (locked_q && st_q == RTCI_ST_TX |-> !sda_oe)
		else $error("data sent after forced end");

	write_seen_c: cover property (reg_wr.valid);
	read_seen_c: cover property (st_q == RTCI_ST_TX_ACK && scl_fall && mack_q);
	timeout_seen_c: cover property (tout_hit);

endmodule // rtci_port
`default_nettype wire

// ### verification/rtci_master_model.sv
// Purpose: Behavioural bus master that drives the link clock and pulls data low.
// Assumes: One link bit takes 8 ref_clk cycles, a 160 ns period.
// Notes: Data is released high by the pull-up whenever low is not asserted.
`timescale 1ns/100ps
`default_nettype none
module rtci_master_model (
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl,
	output logic low
);
	initial
	begin
		scl = 1'b1;
		low = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Bit, byte and framing cycles
	// ----------------------------------------
	// Sampling on the falling ref_clk edge keeps the read clear of flop updates.
	// The clock stays low and high for four cycles each, twice the least the port's sampler needs.
	task automatic bitx(input logic b, output logic r);
		@(posedge ref_clk) low <= !b;
		cyc(2);
		@(posedge ref_clk) scl <= 1'b1;
		cyc(3);
		@(negedge ref_clk) r = sda;
		@(posedge ref_clk) scl <= 1'b0;
	endtask

	task automatic start();
		@(posedge ref_clk) low <= 1'b0;
		cyc(3);
		@(posedge ref_clk) scl <= 1'b1;
		cyc(3);
		@(posedge ref_clk) low <= 1'b1;
		cyc(3);
		@(posedge ref_clk) scl <= 1'b0;
	endtask

	task automatic stop();
		@(posedge ref_clk) low <= 1'b1;
		cyc(3);
		@(posedge ref_clk) scl <= 1'b1;
		cyc(3);
		@(posedge ref_clk) low <= 1'b0;
		cyc(3050);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask

	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(!ack, r);
	endtask
endmodule // rtci_master_model
`default_nettype wire

// ### verification/rtc_i2c_slave_access_port_tb.sv
// Purpose: Self-checking bench for the serial access port.
// Assumes: The register space is modelled here with same-cycle reads.
// Notes: The access limit is cut to 2000 cycles to keep the run short.
`timescale 1ns/100ps
`default_nettype none
module rtc_i2c_slave_access_port_tb;
	import rtci_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic scl, m_low, sda_o, sda_oe, time_hold, ack;
	wire logic sda_w;
	rtci_wr_t reg_wr;
	logic [3:0] reg_rd_addr;
	logic [7:0] mem [16];
	logic [7:0] ref_m [16];
	logic [7:0] v;
	int failures = 0;
	int total_checks = 0;

	// The line is low when either party pulls it; otherwise the pull-up wins.
	assign sda_w = !(m_low || sda_oe);
	rtci_port #(.ACCESS_LIMIT_CYC(2000)) i_dut (.ref_clk(ref_clk), .rst(rst), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(mem[reg_rd_addr]), .time_hold(time_hold));
	rtci_master_model i_mst (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .low(m_low));

	initial
	begin
		forever #10 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk) if (reg_wr.valid === 1'b1) mem[reg_wr.addr] <= reg_wr.data;
	always @(negedge ref_clk) if (sda_oe === 1'b1) check(8'(sda_o), 8'h00);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Checks %0d, failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Method 2 asks for data at once; the other methods use the plain write format.
	function automatic logic [3:0] fmt_for(input int m);
		return (m == 2) ? RTCI_FMT_READ_NOW : RTCI_FMT_WRITE;
	endfunction

	task automatic finish_access();
		i_mst.stop();
		check(8'(time_hold), 8'h00);
		check(8'(reg_rd_addr), 8'h0f);
		check(8'(sda_oe), 8'h00);
	endtask

	task automatic wr(input logic [3:0] p, input int n);
		i_mst.start();
		i_mst.wbyte({RTCI_SLAVE_ADDR, 1'b0}, ack);
		check(8'(ack), 8'h01);
		check(8'(time_hold), 8'h01);
		i_mst.wbyte({p, RTCI_FMT_WRITE}, ack);
		repeat (n)
		begin
			v = 8'($urandom);
			i_mst.wbyte(v, ack);
			check(8'(ack), 8'h01);
			ref_m[p] = v;
			p++;
		end
		finish_access();
		for (int i = 0; i < 16; i++) check(mem[i], ref_m[i]);
	endtask

	// Method 1 repeats the start, 2 reads at once, 3 reads straight after the address.
	task automatic rd(input int m, input logic [3:0] p, input int n);
		i_mst.start();
		if (m != 3) i_mst.wbyte({RTCI_SLAVE_ADDR, 1'b0}, ack);
		if (m != 3) i_mst.wbyte({p, fmt_for(m)}, ack);
		if (m == 1) i_mst.start();
		if (m != 2) i_mst.wbyte({RTCI_SLAVE_ADDR, 1'b1}, ack);
		if (m == 3) p = RTCI_PTR_RESET;
		for (int i = 0; i < n; i++)
		begin
			i_mst.rbyte(i < n - 1, v);
			check(v, ref_m[p]);
			p++;
		end
		i_mst.cyc(6);
		check(8'(sda_oe), 8'h00);
		finish_access();
	endtask

	initial
	begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		results();
	end

	initial
	begin
		void'($urandom(31081));
		for (int i = 0; i < 16; i++) mem[i] = 8'($urandom);
		ref_m = mem;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		i_mst.cyc(4);
		check(8'(reg_rd_addr), 8'h0f);
		wr(4'hd, 4);
		for (int k = 0; k < 3; k++) wr(4'($urandom), 1 + $urandom % 4);
		rd(1, 4'h2, 3);
		rd(2, 4'he, 4);
		rd(3, 4'h0, 3);
		for (int k = 0; k < 4; k++) rd(1 + $urandom % 3, 4'($urandom), 1 + $urandom % 4);
		// A foreign address must be left alone for the whole transfer.
		i_mst.start();
		i_mst.wbyte({RTCI_SLAVE_ADDR ^ 7'(1 + $urandom % 127), 1'b0}, ack);
		check(8'(ack), 8'h00);
		i_mst.wbyte(8'h00, ack);
		check(8'(ack), 8'h00);
		finish_access();
		// An access that outlives the limit is cut off and then locked.
		i_mst.start();
		i_mst.wbyte({RTCI_SLAVE_ADDR, 1'b0}, ack);
		i_mst.wbyte({4'h3, RTCI_FMT_WRITE}, ack);
		i_mst.cyc(2100);
		check(8'(time_hold), 8'h00);
		check(8'(reg_rd_addr), 8'h0f);
		i_mst.start();
		i_mst.wbyte({RTCI_SLAVE_ADDR, 1'b0}, ack);
		check(8'(ack), 8'h00);
		i_mst.start();
		i_mst.wbyte({RTCI_SLAVE_ADDR, 1'b1}, ack);
		i_mst.rbyte(1'b0, v);
		check(v, RTCI_FILL_BYTE);
		finish_access();
		rd(3, 4'h0, 2);
		results();
	end
endmodule // rtc_i2c_slave_access_port_tb
`default_nettype wire
